//--- stpdrv_top.sv
// Step/direction driver control: microstep position, coil current, protection
//
// How it works
// - One microstep per strobe rising edge only
// - Resolution input picks microstep size per version
// - Direction low clockwise, high counter-clockwise
// - Enable low switches coil current off
// - Boost high raises current above nominal
// - Resolution latched only while enable low
// - Standstill with boost low cuts current to two thirds
// - Every strobe up to 200 kHz processed
// - Over-temperature switches the driver off
// - Supply out of range switches driver off
// - Restart needs cleared fault and enable edge
// - Fault clears only past the hysteresis
//
// Local design decisions: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
module stpdrv_top #(
  parameter int STILL_CYC_P = stpdrv_pkg::STILL_CYC,
  parameter bit LOW_NOISE   = 1'b0
) (
  input  wire logic        i_clk,      // 25 MHz system clock
  input  wire logic        i_rst_n,    // Async reset, active low
  input  wire logic        i_step,     // Microstep strobe
  input  wire logic        i_dir,      // Direction, 1 = counter-clockwise
  input  wire logic        i_en,       // Power enable
  input  wire logic        i_boost,    // Torque boost
  input  wire logic        i_res_sel,  // Resolution select
  input  wire logic [7:0]  i_temp_c,   // Motor temperature, degrees C
  input  wire logic [8:0]  i_vsup_dv,  // Supply voltage, tenths of a volt
  input  wire logic [3:0]  i_addr,     // Register address
  input  wire logic [31:0] i_wdata,    // Register write data
  input  wire logic        i_wr,       // Write strobe
  input  wire logic        i_rd,       // Read strobe
  output logic      [31:0] o_rdata,    // Read data, cycle after strobe
  output logic             o_irq,      // Interrupt, level
  output logic             o_coil_on,  // Coil current enabled
  output logic      [7:0]  o_current,  // Coil current scale
  output logic      [15:0] o_position, // Microstep position, 1/256 units
  output logic             o_step_pulse, // One cycle per microstep taken
  output logic             o_shutdown  // Protective shutdown latched
);
  import stpdrv_pkg::*;

  // Synchronised inputs
  logic [4:0]  sync_q;
  logic        step_s;
  logic        dir_s;
  logic        en_s;
  logic        boost_s;
  logic        res_s;
  logic        step_d_reg;
  logic        en_d_reg;
  logic        step_rise;
  logic        en_rise;

  // Step path
  logic        res_reg;
  logic [7:0]  inc;
  logic [15:0] pos_next;
  logic        take_step;

  // Protection
  logic        therm_reg;
  logic        supply_reg;
  logic        temp_hot;
  logic        temp_ok;
  logic        volt_bad;
  logic        volt_ok;
  logic        fault;
  stpdrv_state_t state_reg;
  stpdrv_state_t state_next;

  // Standstill
  logic [23:0] still_lim_reg;
  logic [23:0] idle_cnt_reg;
  logic        still_reg;
  logic        still_next;
  logic [7:0]  cur_next;

  // Registers
  stpdrv_evt_if evt ();
  logic [31:0] rd_mux;
  logic [31:0] state_word;

  stpdrv_sync #(.W(5)) u_sync (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_d     ({i_step, i_dir, i_en, i_boost, i_res_sel}),
    .o_q     (sync_q)
  );

  assign {step_s, dir_s, en_s, boost_s, res_s} = sync_q;

  assign step_rise = step_s & ~step_d_reg;
  assign en_rise   = en_s & ~en_d_reg;

  // Increment per strobe in 1/256 microstep units
  assign inc = LOW_NOISE ? (res_reg ? INC_FINE : INC_EIGHTH)
                         : (res_reg ? INC_EIGHTH : INC_HALF);

  assign take_step = step_rise && (state_reg == ST_RUN);
  assign pos_next  = take_step ? stpdrv_pos_step(o_position, inc, dir_s)
                               : o_position;

  // Trip and release levels with hysteresis
  assign temp_hot = i_temp_c >= TRIP_C;
  assign temp_ok  = i_temp_c <= (TRIP_C - HYST_C);
  assign volt_bad = (i_vsup_dv < VSUP_MIN_DV) || (i_vsup_dv > VSUP_MAX_DV);
  assign volt_ok  = (i_vsup_dv >= (VSUP_MIN_DV + VHYST_DV))
                 && (i_vsup_dv <= (VSUP_MAX_DV - VHYST_DV));
  assign fault    = therm_reg | supply_reg;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_OFF: begin
        if (fault) begin
          state_next = ST_FAULT;
        end else if (en_s) begin
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        if (fault) begin
          state_next = ST_FAULT;
        end else if (!en_s) begin
          state_next = ST_OFF;
        end
      end
      ST_FAULT: begin
        if (!fault && en_rise) begin
          state_next = ST_RUN;
        end
      end
      default: begin
        state_next = ST_OFF;
      end
    endcase
  end

  // Standstill after the programmed idle time; a step cancels it at once
  assign still_next = take_step ? 1'b0
                              : (idle_cnt_reg >= still_lim_reg);

  assign cur_next = (state_next != ST_RUN) ? CUR_OFF
                  : boost_s                ? CUR_BOOST
                  : still_next             ? CUR_RED
                  :                          CUR_NOM;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      step_d_reg <= 1'b0;
      en_d_reg   <= 1'b0;
      res_reg    <= 1'b0;
      therm_reg  <= 1'b0;
      supply_reg <= 1'b0;
      state_reg  <= ST_OFF;
    end else begin
      step_d_reg <= step_s;
      en_d_reg   <= en_s;
      if (!en_s) begin
        res_reg <= res_s;
      end
      therm_reg  <= temp_hot | (therm_reg & ~temp_ok);
      supply_reg <= volt_bad | (supply_reg & ~volt_ok);
      state_reg  <= state_next;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      idle_cnt_reg <= 24'h00_0000;
      still_reg    <= 1'b0;
      o_position   <= 16'h0000;
      o_step_pulse <= 1'b0;
      o_coil_on    <= 1'b0;
      o_current    <= CUR_OFF;
      o_shutdown   <= 1'b0;
    end else begin
      if (take_step) begin
        idle_cnt_reg <= 24'h00_0000;
      end else if (idle_cnt_reg < still_lim_reg) begin
        idle_cnt_reg <= idle_cnt_reg + 24'h00_0001;
      end
      still_reg    <= still_next;
      o_position   <= pos_next;
      o_step_pulse <= take_step;
      o_coil_on    <= state_next == ST_RUN;
      o_current    <= cur_next;
      o_shutdown   <= state_next == ST_FAULT;
    end
  end

  // Register bus
  assign evt.ev[EV_THERM]   = temp_hot & ~therm_reg;
  assign evt.ev[EV_SUPPLY]  = volt_bad & ~supply_reg;
  assign evt.ev[EV_STILL]   = still_next & ~still_reg;
  assign evt.ev[EV_RESTART] = (state_reg == ST_FAULT) && (state_next == ST_RUN);
  assign evt.wr_status      = i_wr && (i_addr == ADDR_STATUS);
  assign evt.wr_mask        = i_wr && (i_addr == ADDR_MASK);
  assign evt.wdata          = i_wdata[EV_W-1:0];

  stpdrv_irq u_irq (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .bus     (evt)
  );

  assign state_word = {10'h000, supply_reg, therm_reg, res_reg, still_reg,
                       o_shutdown, o_coil_on, o_position};

  assign rd_mux = (i_addr == ADDR_STATUS) ? {28'h000_0000, evt.status}
                : (i_addr == ADDR_MASK)   ? {28'h000_0000, evt.mask}
                : (i_addr == ADDR_STATE)  ? state_word
                : (i_addr == ADDR_STILL)  ? {8'h00, still_lim_reg}
                :                           32'h0000_0000;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      still_lim_reg <= 24'(STILL_CYC_P);
      o_rdata       <= 32'h0000_0000;
      o_irq         <= 1'b0;
    end else begin
      if (i_wr && (i_addr == ADDR_STILL)) begin
        still_lim_reg <= i_wdata[23:0];
      end
      o_rdata <= i_rd ? rd_mux : 32'h0000_0000;
      o_irq   <= evt.irq;
    end
  end

  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  step_adv_a: assert property (
    take_step && !dir_s |=> o_position == stpdrv_pos_step($past(o_position), $past(inc), 1'b0))
    else $error("Clockwise step did not advance position");
  no_step_a: assert property (
    !take_step |=> $stable(o_position) && !o_step_pulse)
    else $error("Position moved without a rising strobe");
  step_size_a: assert property (
    (state_reg == ST_RUN) |-> (POS_MOD / {9'h000, inc}) == (LOW_NOISE
      ? (res_reg ? 17'h0_c800 : 17'h0_0640) : (res_reg ? 17'h0_0640 : 17'h0_0190)))
    else $error("Wrong microstep size");
  ccw_step_a: assert property (
    take_step && dir_s |=> o_position == stpdrv_pos_step($past(o_position), $past(inc), 1'b1))
    else $error("Counter-clockwise step wrong");
  coil_off_a: assert property (
    !en_s |=> !o_coil_on && (o_current == CUR_OFF))
    else $error("Coil current on with enable low");
  boost_cur_a: assert property (
    (state_next == ST_RUN) && boost_s |=> o_current == CUR_BOOST)
    else $error("Boost current missing");
  res_hold_a: assert property (
    en_s |=> $stable(res_reg))
    else $error("Resolution changed while enabled");
  still_red_a: assert property (
    (state_next == ST_RUN) && !boost_s && still_next |=> o_current == CUR_RED)
    else $error("Standstill current not reduced");
  every_step_a: assert property (
    step_rise && (state_reg == ST_RUN) |=> o_step_pulse ##1 !o_step_pulse)
    else $error("Strobe edge not processed once");
  therm_off_a: assert property (
    temp_hot |=> ##1 !o_coil_on && o_shutdown)
    else $error("Over-temperature did not shut down");
  supply_off_a: assert property (
    volt_bad |=> ##1 !o_coil_on && o_shutdown)
    else $error("Supply fault did not shut down");
  restart_a: assert property (
    (state_reg == ST_FAULT) && !(en_rise && !fault) |=> !o_coil_on)
    else $error("Restart without cleared fault and enable edge");
  hyst_a: assert property (
    therm_reg && !temp_ok |=> therm_reg)
    else $error("Thermal fault released inside hysteresis");
  still_restore_a: assert property (
    take_step |=> !still_reg)
    else $error("Step did not cancel standstill");
  sync_delay_a: assert property (
    en_s == $past(i_en, 2))
    else $error("Enable not two flops behind the pin");
  // Strobe path, supply release, interrupt and read bus
  step_sync_a: assert property (
    step_s == $past(i_step, 2))
    else $error("Strobe not two flops behind the pin");
  vhyst_a: assert property (
    supply_reg && !volt_ok |=> supply_reg)
    else $error("Supply fault released inside hysteresis");
  irq_level_a: assert property (
    o_irq == $past(|(evt.status & evt.mask)))
    else $error("Interrupt does not follow unmasked status");
  rd_idle_a: assert property (
    !i_rd |=> o_rdata == 32'h0000_0000)
    else $error("Read data not zero after idle cycle");

  step_taken_c: cover property (take_step ##1 o_step_pulse);
  still_entered_c: cover property (!still_reg ##1 still_reg);
  shutdown_c: cover property ((state_reg == ST_RUN) ##1 (state_reg == ST_FAULT));
  restart_c: cover property ((state_reg == ST_FAULT) ##1 (state_reg == ST_RUN));
  boost_still_c: cover property (still_reg && boost_s && (o_current == CUR_BOOST));
endmodule

//--- stpdrv_pkg.sv
// Constants, types and shared arithmetic of the step/direction driver control
package stpdrv_pkg;

  // Clock and timing
  localparam int CLK_HZ        = 25_000_000;
  localparam int CLK_NS        = 40;
  localparam int STEP_MAX_KHZ  = 200;
  localparam int STEP_MIN_CYC  = (CLK_HZ / 1000) / STEP_MAX_KHZ;
  localparam int STILL_TIME_US = 20_000;
  localparam int STILL_CYC     = STILL_TIME_US * (CLK_HZ / 1_000_000);

  // Protection thresholds, degrees C and tenths of a volt
  localparam logic [7:0] TRIP_C      = 8'h64;
  localparam logic [7:0] HYST_C      = 8'h0a;
  localparam logic [8:0] VSUP_MIN_DV = 9'h0c0;
  localparam logic [8:0] VSUP_MAX_DV = 9'h120;
  localparam logic [8:0] VHYST_DV    = 9'h00a;

  // Position in 1/256 microsteps over one revolution
  localparam logic [16:0] POS_MOD    = 17'h0_c800;
  localparam logic [7:0]  INC_HALF   = 8'h80;
  localparam logic [7:0]  INC_EIGHTH = 8'h20;
  localparam logic [7:0]  INC_FINE   = 8'h01;

  // Coil current scale: reduced is exactly 2/3 of nominal
  localparam logic [7:0] CUR_OFF   = 8'h00;
  localparam logic [7:0] CUR_RED   = 8'h60;
  localparam logic [7:0] CUR_NOM   = 8'h90;
  localparam logic [7:0] CUR_BOOST = 8'hc0;

  // Register map
  localparam logic [3:0] ADDR_STATUS = 4'h0;
  localparam logic [3:0] ADDR_MASK   = 4'h4;
  localparam logic [3:0] ADDR_STATE  = 4'h8;
  localparam logic [3:0] ADDR_STILL  = 4'hc;
  localparam int         EV_W        = 4;
  localparam int         EV_THERM    = 0;
  localparam int         EV_SUPPLY   = 1;
  localparam int         EV_STILL    = 2;
  localparam int         EV_RESTART  = 3;
  localparam logic [3:0] MASK_RST    = 4'h0;

  typedef enum logic [1:0] {ST_OFF, ST_RUN, ST_FAULT} stpdrv_state_t;

  // One microstep forward or back, wrapping at one revolution
  function automatic logic [15:0] stpdrv_pos_step(input logic [15:0] pos,
                                                  input logic [7:0]  inc,
                                                  input logic        ccw);
    logic [16:0] sum;
    sum = 17'h0_0000;
    if (!ccw) begin
      sum = {1'b0, pos} + {9'h000, inc};
      if (sum >= POS_MOD) begin
        sum = sum - POS_MOD;
      end
    end else if (pos >= {8'h00, inc}) begin
      sum = {1'b0, pos} - {9'h000, inc};
    end else begin
      sum = {1'b0, pos} + POS_MOD - {9'h000, inc};
    end
    return sum[15:0];
  endfunction

endpackage

//--- stpdrv_evt_if.sv
// Event and interrupt register link between control core and event block
`timescale 1ns/1ps
interface stpdrv_evt_if;
  import stpdrv_pkg::*;
  logic [EV_W-1:0] ev;
  logic            wr_status;
  logic            wr_mask;
  logic [EV_W-1:0] wdata;
  logic [EV_W-1:0] status;
  logic [EV_W-1:0] mask;
  logic            irq;
  modport ctrl (output ev, wr_status, wr_mask, wdata, input status, mask, irq);
  modport evt  (input ev, wr_status, wr_mask, wdata, output status, mask, irq);
endinterface

//--- stpdrv_sync.sv
// Two flip-flop synchroniser for the control inputs
`timescale 1ns/1ps
module stpdrv_sync #(
  parameter int W = 5
) (
  input  wire logic         i_clk,   // System clock
  input  wire logic         i_rst_n, // Async reset, active low
  input  wire logic [W-1:0] i_d,     // Asynchronous inputs
  output logic      [W-1:0] o_q      // Synchronised outputs
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_reg <= '0;
      o_q      <= '0;
    end else begin
      meta_reg <= i_d;
      o_q      <= meta_reg;
    end
  end
endmodule

//--- stpdrv_irq.sv
// Sticky event status, mask and level interrupt
`timescale 1ns/1ps
module stpdrv_irq (
  input  wire logic   i_clk,   // System clock
  input  wire logic   i_rst_n, // Async reset, active low
  stpdrv_evt_if.evt   bus      // Events in, status out
);
  import stpdrv_pkg::*;

  logic [EV_W-1:0] status_reg;
  logic [EV_W-1:0] status_next;
  logic [EV_W-1:0] mask_reg;
  logic [EV_W-1:0] mask_next;
  logic            irq_reg;

  // Write one to clear; a new event in the same cycle wins
  assign status_next = (status_reg & ~(bus.wr_status ? bus.wdata : '0)) | bus.ev;
  assign mask_next   = bus.wr_mask ? bus.wdata : mask_reg;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      status_reg <= '0;
      mask_reg   <= MASK_RST;
      irq_reg    <= 1'b0;
    end else begin
      status_reg <= status_next;
      mask_reg   <= mask_next;
      irq_reg    <= |(status_next & mask_next);
    end
  end

  assign bus.status = status_reg;
  assign bus.mask   = mask_reg;
  assign bus.irq    = irq_reg;

  set_wins_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (bus.ev != '0) |=> ((status_reg & $past(bus.ev)) == $past(bus.ev)))
    else $error("Event lost against a status clear");
endmodule

//--- stpdrv_ctl_model.sv
// Motion controller model: bursts of microstep strobes with a direction level
`timescale 1ns/1ps
module stpdrv_ctl_model #(
  parameter int HALF = 63  // Clocks per strobe level: 2.52 us, about 198 kHz
) (
  input  wire logic       i_clk,   // System clock
  input  wire logic       i_rst_n, // Reset, active low
  input  wire logic       i_go,    // Start a burst
  input  wire logic [7:0] i_count, // Strobes in the burst
  input  wire logic       i_ccw,   // Direction for the burst
  output logic            o_step,  // Microstep strobe
  output logic            o_dir,   // Direction level
  output logic            o_busy   // Burst in progress
);
  logic [7:0] left_reg;
  logic [7:0] cnt_reg;

  assign o_busy = (left_reg != 8'h00);

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      left_reg <= 8'h00;
      cnt_reg  <= 8'h00;
      o_step   <= 1'b0;
      o_dir    <= 1'b0;
    end else if (i_go && !o_busy) begin
      left_reg <= i_count;
      o_dir    <= i_ccw; // Direction moves only while strobe is low
      cnt_reg  <= 8'h00;
    end else if (o_busy) begin
      if (cnt_reg == 8'(HALF - 1)) begin
        cnt_reg <= 8'h00;
        o_step  <= ~o_step;
        if (o_step) begin
          left_reg <= left_reg - 8'h01;
        end
      end else begin
        cnt_reg <= cnt_reg + 8'h01;
      end
    end
  end
endmodule

//--- tb.sv
// Self-checking bench for the step/direction driver control
`timescale 1ns/1ps
module tb;
  import stpdrv_pkg::*;
  logic        i_clk = 1'b0, i_rst_n = 1'b0, i_en = 1'b0, i_boost = 1'b0;
  logic        i_res_sel = 1'b0, i_wr = 1'b0, i_rd = 1'b0, go = 1'b0, ccw = 1'b0;
  logic [7:0]  i_temp_c = 8'h19, cnt = 8'h00;
  logic [8:0]  i_vsup_dv = 9'h0f0;
  logic [3:0]  i_addr = 4'h0;
  logic [31:0] i_wdata = 32'h0000_0000, rd, o_rdata;
  logic        step, dir, busy, o_irq, o_coil_on, o_step_pulse, o_shutdown;
  logic [7:0]  o_current;
  logic [15:0] o_position, pos_ln;
  int          n_fail = 0, checks_done = 0, n_pulse = 0, exp_s = 0, exp_l = 0;

  always #20 i_clk = ~i_clk;
  always @(posedge i_clk) if (o_step_pulse === 1'b1) n_pulse <= n_pulse + 1;

  stpdrv_ctl_model stpdrv_ctl_model_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_go(go),
    .i_count(cnt), .i_ccw(ccw), .o_step(step), .o_dir(dir), .o_busy(busy));

  stpdrv_top #(.STILL_CYC_P(200), .LOW_NOISE(1'b0)) stpdrv_top_i (.i_clk(i_clk),
    .i_rst_n(i_rst_n), .i_step(step), .i_dir(dir), .i_en(i_en), .i_boost(i_boost),
    .i_res_sel(i_res_sel), .i_temp_c(i_temp_c), .i_vsup_dv(i_vsup_dv), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq),
    .o_coil_on(o_coil_on), .o_current(o_current), .o_position(o_position),
    .o_step_pulse(o_step_pulse), .o_shutdown(o_shutdown));

  // Low-noise version shares every input; only its position is compared
  stpdrv_top #(.STILL_CYC_P(200), .LOW_NOISE(1'b1)) stpdrv_top_ln_i (.i_clk(i_clk),
    .i_rst_n(i_rst_n), .i_step(step), .i_dir(dir), .i_en(i_en), .i_boost(i_boost),
    .i_res_sel(i_res_sel), .i_temp_c(i_temp_c), .i_vsup_dv(i_vsup_dv), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(), .o_irq(), .o_coil_on(),
    .o_current(), .o_position(pos_ln), .o_step_pulse(), .o_shutdown());

  task automatic tally_and_finish();
    if (n_fail == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [3:0] a);
    @(posedge i_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    rd = o_rdata;
  endtask

  // Burst of strobes; live says whether the driver should follow them
  task automatic steps(input int n, input logic c, input int inc_s, input int inc_l,
                       input bit live);
    int lim;
    lim = 0;
    n_pulse = 0;
    @(posedge i_clk);
    go  <= 1'b1;
    cnt <= n[7:0];
    ccw <= c;
    @(posedge i_clk);
    go <= 1'b0;
    #1;
    while (busy === 1'b1 && lim < 40000) begin
      @(posedge i_clk);
      #1;
      lim++;
    end
    if (lim >= 40000) begin
      n_fail++;
      tally_and_finish();
    end
    cyc(6);
    if (live) begin
      exp_s = ((exp_s + (c ? -n * inc_s : n * inc_s)) % 51200 + 51200) % 51200;
      exp_l = ((exp_l + (c ? -n * inc_l : n * inc_l)) % 51200 + 51200) % 51200;
    end
    chk("pulses", live ? 32'(n) : 32'h0000_0000, 32'(n_pulse));
    chk("position", 32'(exp_s), {16'h0000, o_position});
    chk("position_ln", 32'(exp_l), {16'h0000, pos_ln});
  endtask

  task automatic en_edge();
    @(posedge i_clk);
    i_en <= 1'b0;
    cyc(4);
    @(posedge i_clk);
    i_en <= 1'b1;
    cyc(6);
  endtask

  task automatic vcase(input logic [8:0] bad, input logic [8:0] mid, input logic [8:0] ok);
    @(posedge i_clk);
    i_vsup_dv <= bad;
    cyc(4);
    chk("vfault_off", 32'h0000_0001, {31'h0, o_shutdown});
    @(posedge i_clk);
    i_vsup_dv <= mid;
    en_edge();
    chk("vhyst_held", 32'h0000_0001, {31'h0, o_shutdown});
    @(posedge i_clk);
    i_vsup_dv <= ok;
    en_edge();
    chk("vrestart", 32'h0000_0001, {31'h0, o_coil_on});
  endtask

  initial begin
    repeat (6) @(posedge i_clk);
    i_rst_n <= 1'b1;
    rd_reg(ADDR_STATE);
    chk("state_rst", 32'h0000_0000, rd);
    rd_reg(ADDR_MASK);
    chk("mask_rst", {28'h0, MASK_RST}, rd);
    rd_reg(ADDR_STILL);
    chk("still_rst", 32'h0000_00c8, rd);
    wr_reg(ADDR_STILL, 32'hff00_0096);
    rd_reg(ADDR_STILL);
    chk("still_lim", 32'h0000_0096, rd);
    wr_reg(4'h2, 32'hffff_ffff);
    rd_reg(4'h2);
    chk("unmapped", 32'h0000_0000, rd);
    wr_reg(ADDR_STATE, 32'hffff_ffff);
    rd_reg(ADDR_STATE);
    chk("state_ro", 32'h0000_0000, rd);
    wr_reg(ADDR_MASK, 32'h0000_0001);
    @(posedge i_clk);
    i_en <= 1'b1;
    cyc(6);
    chk("coil_on", 32'h0000_0001, {31'h0, o_coil_on});
    steps(3, 1'b0, 128, 32, 1'b1);
    chk("cur_nom", {24'h0, CUR_NOM}, {24'h0, o_current});
    steps(5, 1'b1, 128, 32, 1'b1);
    cyc(210);
    chk("cur_still", {24'h0, CUR_RED}, {24'h0, o_current});
    rd_reg(ADDR_STATUS);
    chk("still_evt", 32'h0000_0001, {31'h0, rd[EV_STILL]});
    @(posedge i_clk);
    i_boost <= 1'b1;
    cyc(4);
    chk("cur_boost", {24'h0, CUR_BOOST}, {24'h0, o_current});
    @(posedge i_clk);
    i_boost <= 1'b0;
    cyc(4);
    chk("cur_unboost", {24'h0, CUR_RED}, {24'h0, o_current});
    steps(1, 1'b0, 128, 32, 1'b1);
    chk("cur_wake", {24'h0, CUR_NOM}, {24'h0, o_current});
    // Resolution moved while enabled on purpose: must be ignored
    @(posedge i_clk);
    i_res_sel <= 1'b1;
    cyc(6);
    steps(1, 1'b0, 128, 32, 1'b1);
    @(posedge i_clk);
    i_en <= 1'b0;
    cyc(4);
    chk("coil_off", 32'h0000_0000, {23'h0, o_coil_on, o_current});
    @(posedge i_clk);
    i_en <= 1'b1;
    cyc(6);
    steps(2, 1'b0, 32, 1, 1'b1);
    @(posedge i_clk);
    i_temp_c <= 8'h64;
    cyc(4);
    chk("tfault", 32'h0000_0100, {23'h0, o_shutdown, o_current});
    chk("irq_on", 32'h0000_0001, {31'h0, o_irq});
    steps(2, 1'b0, 32, 1, 1'b0);
    @(posedge i_clk);
    i_temp_c <= 8'h5f;
    en_edge();
    chk("thyst_held", 32'h0000_0001, {31'h0, o_shutdown});
    @(posedge i_clk);
    i_temp_c <= 8'h5a;
    cyc(6);
    chk("en_high_held", 32'h0000_0001, {31'h0, o_shutdown});
    en_edge();
    chk("trestart", 32'h0000_0001, {31'h0, o_coil_on});
    wr_reg(ADDR_STATUS, 32'h0000_0001);
    rd_reg(ADDR_STATUS);
    chk("w1c", 32'h0000_0000, {31'h0, rd[EV_THERM]});
    chk("irq_off", 32'h0000_0000, {31'h0, o_irq});
    vcase(9'h0bf, 9'h0c9, 9'h0ca);
    vcase(9'h121, 9'h117, 9'h116);
    steps(1, 1'b1, 32, 1, 1'b1);
    tally_and_finish();
  end
endmodule
